//--- verilog/uoc_pkg.sv
/*
 * Constants of the interface mode and OTG power control registers:
 * register addresses, bit positions and reset values.
 * Assumes a ULPI register access layer that hands over decoded
 * addresses and data one access at a time.
 */
package uoc_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;

    // Interface mode control: read at any of three, write/set/clear
    localparam logic [5:0] IMC_WRITE_ADDR = 6'h07;
    localparam logic [5:0] IMC_SET_ADDR   = 6'h08;
    localparam logic [5:0] IMC_CLEAR_ADDR = 6'h09;
    // OTG power control
    localparam logic [5:0] OPC_WRITE_ADDR = 6'h0a;
    localparam logic [5:0] OPC_SET_ADDR   = 6'h0b;
    localparam logic [5:0] OPC_CLEAR_ADDR = 6'h0c;

    localparam logic [7:0] IMC_RESET = 8'h00;
    localparam logic [7:0] OPC_RESET = 8'h06;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Interface mode control fields
    localparam int IMC_GUARD_DISABLE = 7;
    localparam int IMC_UNGATED       = 6;
    localparam int IMC_INVERT        = 5;
    localparam int IMC_CLOCK_KEEP_N  = 3;
    localparam int IMC_CARKIT        = 2;
    localparam int IMC_THREE_WIRE    = 1;
    localparam int IMC_SIX_WIRE      = 0;

    // OTG power control fields
    localparam int OPC_EXT_SELECT    = 7;
    localparam int OPC_POWER_SWITCH  = 6;
    localparam int OPC_CHARGE        = 4;
    localparam int OPC_DISCHARGE     = 3;
    localparam int OPC_MINUS_PD      = 2;
    localparam int OPC_PLUS_PD       = 1;
    localparam int OPC_ID_SENSE      = 0;

    // Kind of register write
    typedef enum logic [1:0] {
        UOC_OP_NONE  = 2'b00,
        UOC_OP_WRITE = 2'b01,
        UOC_OP_SET   = 2'b11,
        UOC_OP_CLEAR = 2'b10
    } uoc_op_e;

endpackage

//--- verilog/uoc_control_regs.sv
/*
 * Interface mode control and OTG power control registers of a ULPI
 * OTG transceiver, with the pin conditioning they steer.
 * Assumes the ULPI protocol layer delivers one register access per
 * strobe, synchronous to clk, and that mode exit events come from
 * the serial/UART engines as one-cycle pulses.
 */
module uoc_control_regs
    import uoc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    // Register access from the ULPI protocol layer
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic                   reg_rdata_valid,
    // Device state
    input  wire logic              phy_active_n,
    input  wire logic              carkit_exit,
    input  wire logic              three_wire_exit,
    input  wire logic              six_wire_exit,
    input  wire logic              stp_in,
    input  wire logic              stp_expected,
    input  wire logic              fault_in,
    input  wire logic              vbus_valid_compare,
    // Conditioned outputs
    output logic                   stp_pullup_en,
    output logic                   data_pulldown_en,
    output logic                   link_released,
    output logic                   vbus_status,
    output logic                   serial_clock_on,
    output logic                   carkit_mode,
    output logic                   three_wire_serial_enable,
    output logic                   six_wire_serial_enable,
    output logic                   power_switch_out_n,
    output logic                   vbus_charge,
    output logic                   vbus_discharge,
    output logic                   minus_line_pulldown,
    output logic                   plus_line_pulldown,
    output logic                   id_sense_enable
);

    // Decode works on six address bits and whole bytes only
    if (ADDR_W != 6 || DATA_W != 8)
    begin
        $error("uoc_control_regs: unsupported bus widths");
    end

    function automatic logic [7:0] apply_op(input logic [7:0] old,
                                            input uoc_op_e    op,
                                            input logic [7:0] data);
        case (op)
            UOC_OP_WRITE: apply_op = data;
            UOC_OP_SET:   apply_op = old | data;
            UOC_OP_CLEAR: apply_op = old & ~data;
            default:      apply_op = old;
        endcase
    endfunction

    function automatic uoc_op_e decode_op(input logic [5:0] a,
                                          input logic [5:0] base);
        if (a == base)
            decode_op = UOC_OP_WRITE;
        else if (a == base + 6'h01)
            decode_op = UOC_OP_SET;
        else if (a == base + 6'h02)
            decode_op = UOC_OP_CLEAR;
        else
            decode_op = UOC_OP_NONE;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register file

    logic [7:0] iface_mode;
    logic [7:0] otg_power;

    wire uoc_op_e    imc_op      = uoc_op_e'(reg_write ? decode_op(reg_addr, IMC_WRITE_ADDR)
                                             : UOC_OP_NONE);
    wire uoc_op_e    opc_op      = uoc_op_e'(reg_write ? decode_op(reg_addr, OPC_WRITE_ADDR)
                                             : UOC_OP_NONE);
    wire logic       imc_hit     = decode_op(reg_addr, IMC_WRITE_ADDR) != UOC_OP_NONE;
    wire logic       opc_hit     = decode_op(reg_addr, OPC_WRITE_ADDR) != UOC_OP_NONE;
    // Exits clear first so a write in the same cycle wins
    wire logic [7:0] exit_mask   = {5'b0_0000, carkit_exit, three_wire_exit,
                                    six_wire_exit};
    wire logic [7:0] next_iface  = apply_op(iface_mode & ~exit_mask, imc_op, reg_wdata);
    wire logic [7:0] next_otg    = apply_op(otg_power, opc_op, reg_wdata);
    wire logic [7:0] next_rdata  = imc_hit ? iface_mode
                                 : opc_hit ? otg_power : READ_ZERO;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            iface_mode      <= IMC_RESET;
            otg_power       <= OPC_RESET;
            reg_rdata       <= READ_ZERO;
            reg_rdata_valid <= 1'b0;
        end
        else
        begin
            iface_mode      <= next_iface;
            otg_power       <= next_otg;
            reg_rdata       <= reg_read ? next_rdata : reg_rdata;
            reg_rdata_valid <= reg_read;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin conditioning

    wire logic guard_on     = !iface_mode[IMC_GUARD_DISABLE];
    // STP high with the link not asserting it means released pins
    wire logic stp_floating = stp_in && !stp_expected;
    wire logic complement   = fault_in ^ iface_mode[IMC_INVERT];
    wire logic indicator    = iface_mode[IMC_UNGATED] ? complement
                            : complement && vbus_valid_compare;
    wire logic next_status  = otg_power[OPC_EXT_SELECT] ? indicator
                            : vbus_valid_compare;
    // Multiple modes set is the link's fault; any one counts here
    wire logic alt_mode     = |iface_mode[IMC_CARKIT:IMC_SIX_WIRE];
    wire logic next_clk_on  = !(alt_mode && phy_active_n)
                            || iface_mode[IMC_CLOCK_KEEP_N];

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            stp_pullup_en      <= 1'b1;
            data_pulldown_en   <= 1'b0;
            link_released      <= 1'b0;
            vbus_status        <= 1'b0;
            serial_clock_on    <= 1'b1;
            power_switch_out_n <= 1'b1;
        end
        else
        begin
            stp_pullup_en      <= guard_on;
            data_pulldown_en   <= guard_on && stp_floating;
            link_released      <= guard_on && stp_floating;
            vbus_status        <= next_status;
            serial_clock_on    <= next_clk_on;
            power_switch_out_n <= !otg_power[OPC_POWER_SWITCH];
        end
    end

    // Straight copies of register bits, one flop later
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            carkit_mode              <= 1'b0;
            three_wire_serial_enable <= 1'b0;
            six_wire_serial_enable   <= 1'b0;
            vbus_charge              <= 1'b0;
            vbus_discharge           <= 1'b0;
            minus_line_pulldown      <= 1'b1;
            plus_line_pulldown       <= 1'b1;
            id_sense_enable          <= 1'b0;
        end
        else
        begin
            carkit_mode              <= iface_mode[IMC_CARKIT];
            three_wire_serial_enable <= iface_mode[IMC_THREE_WIRE];
            six_wire_serial_enable   <= iface_mode[IMC_SIX_WIRE];
            // Link owns the SRP timing before charging
            vbus_charge              <= otg_power[OPC_CHARGE];
            vbus_discharge           <= otg_power[OPC_DISCHARGE];
            minus_line_pulldown      <= otg_power[OPC_MINUS_PD];
            plus_line_pulldown       <= otg_power[OPC_PLUS_PD];
            id_sense_enable          <= otg_power[OPC_ID_SENSE];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_read_imc;
        reg_read && imc_hit;
    endsequence

    sequence s_read_opc;
        reg_read && opc_hit;
    endsequence

    a_read_iface_back: assert property (s_read_imc |=> reg_rdata_valid
        && reg_rdata == $past(iface_mode))
        else $error("interface register read returned wrong value");

    a_read_otg_back: assert property (s_read_opc |=> reg_rdata_valid
        && reg_rdata == $past(otg_power))
        else $error("OTG register read returned wrong value");

    a_set_ors_in: assert property (reg_write && reg_addr == OPC_SET_ADDR
        |=> otg_power == ($past(otg_power) | $past(reg_wdata)))
        else $error("set access did not OR into register");

    a_clear_drops_ones: assert property (reg_write
        && reg_addr == IMC_CLEAR_ADDR && !carkit_exit && !three_wire_exit
        && !six_wire_exit |=> iface_mode == ($past(iface_mode) & ~$past(reg_wdata)))
        else $error("clear access did not remove bits");

    a_guard_pulls_off: assert property (!guard_on [*2]
        |-> !stp_pullup_en && !data_pulldown_en)
        else $error("weak pulls remain with guard disabled");

    a_guard_pulldown: assert property (guard_on && stp_in && !stp_expected
        |=> data_pulldown_en && link_released)
        else $error("floating STP did not raise data pull-downs");

    a_indicator_gate: assert property (otg_power[OPC_EXT_SELECT]
        && !iface_mode[IMC_UNGATED] && !vbus_valid_compare |=> !vbus_status)
        else $error("gated indicator passed without comparator");

    a_power_switch: assert property ($rose(otg_power[OPC_POWER_SWITCH])
        |=> !power_switch_out_n)
        else $error("power switch output did not go low");

    a_carkit_exit: assert property (carkit_exit && !reg_write
        |=> !iface_mode[IMC_CARKIT] ##1 !carkit_mode)
        else $error("carkit bit not cleared on exit");

    a_clock_keep: assert property (alt_mode && phy_active_n
        && !iface_mode[IMC_CLOCK_KEEP_N] |=> !serial_clock_on)
        else $error("serial clock powered against keep bit");

endmodule

//--- bench/uoc_link_model.sv
/* Link side model: issues single register accesses, one at a time.
   Assumes the bench calls wr and rd hierarchically after reset. */
module uoc_link_model
(
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rdata_valid,
    output logic            reg_write,
    output logic            reg_read,
    output logic      [5:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Carkit UART enables sit in a register outside this block
    initial
    begin
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 6'h3f;
        reg_wdata = 8'h00;
    end
    // Released lines show the inverse, never the old value
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_write = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        // Mirrored outputs land one edge after the update
        @(negedge clk);
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic v);
        @(negedge clk);
        reg_read = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_read = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
        v = reg_rdata_valid;
    endtask
endmodule

//--- bench/testbench.sv
/* Self-checking bench of the interface mode and OTG power registers.
   Assumes the link model is the only register master. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, resetn = 1'b0, reg_write, reg_read, reg_rdata_valid, v;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic       phy_active_n = 1'b1, carkit_exit = 1'b0, three_wire_exit = 1'b0;
    logic       six_wire_exit = 1'b0, stp_in = 1'b0, stp_expected = 1'b0;
    logic       fault_in = 1'b0, vbus_valid_compare = 1'b0, stp_pullup_en;
    logic       data_pulldown_en, link_released, vbus_status, serial_clock_on;
    logic       carkit_mode, three_wire_serial_enable, six_wire_serial_enable;
    logic       power_switch_out_n, vbus_charge, vbus_discharge, minus_line_pulldown;
    logic       plus_line_pulldown, id_sense_enable;
    int         fails = 0, samples_checked = 0, cycles = 0;
    always #2.5 clk = ~clk;
    uoc_control_regs dut(.clk, .resetn, .reg_write, .reg_read, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rdata_valid, .phy_active_n, .carkit_exit, .three_wire_exit,
        .six_wire_exit, .stp_in, .stp_expected, .fault_in, .vbus_valid_compare,
        .stp_pullup_en, .data_pulldown_en, .link_released, .vbus_status,
        .serial_clock_on, .carkit_mode, .three_wire_serial_enable,
        .six_wire_serial_enable, .power_switch_out_n, .vbus_charge, .vbus_discharge,
        .minus_line_pulldown, .plus_line_pulldown, .id_sense_enable);
    uoc_link_model link(.clk, .reg_rdata, .reg_rdata_valid, .reg_write, .reg_read,
        .reg_addr, .reg_wdata);
    task automatic summarize();
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
        link.rd(a, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rchk(6'h07, 8'h00);
        rchk(6'h0a, 8'h06);
        chk({2'b00, stp_pullup_en, data_pulldown_en, power_switch_out_n,
            minus_line_pulldown, plus_line_pulldown, id_sense_enable}, 8'h2e);
    endtask
    task automatic t_iface();
        link.wr(6'h07, 8'h60);
        link.wr(6'h08, 8'h02); // One mode bit only
        rchk(6'h09, 8'h62);
        link.wr(6'h09, 8'h40);
        rchk(6'h08, 8'h22);
        chk({7'h00, three_wire_serial_enable}, 8'h01);
        three_wire_exit = 1'b1;
        tick(1);
        three_wire_exit = 1'b0;
        tick(1);
        chk({7'h00, three_wire_serial_enable}, 8'h00);
        rchk(6'h07, 8'h20);
        link.wr(6'h07, 8'h00);
    endtask
    task automatic t_otg();
        link.wr(6'h0c, 8'h08); // Discharge known off before charging
        link.wr(6'h0a, 8'hd0);
        rchk(6'h0b, 8'hd0);
        chk({6'h00, power_switch_out_n, vbus_charge}, 8'h01);
        link.wr(6'h0c, 8'h50);
        link.wr(6'h0b, 8'h0f);
        rchk(6'h0c, 8'h8f);
        chk({2'b00, power_switch_out_n, vbus_charge, vbus_discharge, minus_line_pulldown,
            plus_line_pulldown, id_sense_enable}, 8'h2f);
        link.wr(6'h0c, 8'h08); // Link ends the discharge
        link.wr(6'h20, 8'hff);
        rchk(6'h20, 8'h00);
        rchk(6'h0a, 8'h87);
        link.wr(6'h0a, 8'h06);
    endtask
    task automatic t_guard();
        stp_expected = 1'b1;
        stp_in = 1'b1;
        tick(2);
        chk({5'h00, stp_pullup_en, data_pulldown_en, link_released}, 8'h04);
        stp_expected = 1'b0;
        tick(2);
        chk({5'h00, stp_pullup_en, data_pulldown_en, link_released}, 8'h07);
        link.wr(6'h08, 8'h80);
        chk({5'h00, stp_pullup_en, data_pulldown_en, link_released}, 8'h00);
        stp_in = 1'b0;
        link.wr(6'h09, 8'h80);
        chk({5'h00, stp_pullup_en, data_pulldown_en, link_released}, 8'h04);
    endtask
    task automatic t_vbus();
        for (int i = 0; i < 16; i++)
        begin
            link.wr(6'h07, {1'b0, i[3], i[2], 5'h00});
            link.wr(6'h0a, 8'h86);
            fault_in = i[0];
            vbus_valid_compare = i[1];
            tick(2);
            chk({7'h00, vbus_status},
                {7'h00, i[3] ? i[0] ^ i[2] : (i[0] ^ i[2]) & i[1]});
            link.wr(6'h0a, 8'h06);
            chk({7'h00, vbus_status}, {7'h00, i[1]});
        end
    endtask
    task automatic t_serial();
        link.wr(6'h07, 8'h01); // One mode bit only
        chk({6'h00, six_wire_serial_enable, serial_clock_on}, 8'h02);
        link.wr(6'h08, 8'h08);
        chk({7'h00, serial_clock_on}, 8'h01);
        link.wr(6'h09, 8'h08);
        phy_active_n = 1'b0;
        tick(2);
        chk({7'h00, serial_clock_on}, 8'h01);
        phy_active_n = 1'b1;
        six_wire_exit = 1'b1;
        tick(1);
        six_wire_exit = 1'b0;
        tick(1);
        chk({6'h00, six_wire_serial_enable, serial_clock_on}, 8'h01);
        link.wr(6'h07, 8'h04); // One mode bit only
        chk({6'h00, carkit_mode, serial_clock_on}, 8'h02);
        carkit_exit = 1'b1;
        tick(1);
        carkit_exit = 1'b0;
        rchk(6'h07, 8'h00);
    endtask
    task automatic t_rerun();
        // Dirty both registers, then a short mid-run reset
        link.wr(6'h07, 8'h80);
        link.wr(6'h0a, 8'h41);
        resetn = 1'b0;
        tick(2);
        resetn = 1'b1;
        t_reset();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Whole run is well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            summarize();
        end
    end
    initial
    begin
        tick(16);
        resetn = 1'b1;
        t_reset();
        t_iface();
        t_otg();
        t_guard();
        t_vbus();
        t_serial();
        t_rerun();
        summarize();
    end
endmodule
